//--- verilog/memmap_pkg.sv
package memmap_pkg;
  // APB register map (byte addresses)
  localparam logic [11:0] MODE_REG_OFF = 12'h000;
  localparam logic [11:0] FLASH_CTL_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  localparam logic [11:0] REGMAP_OFF = 12'h00C;
  // Mode register fields
  localparam int MODE_BIT = 0;
  localparam int PMAP_BIT = 1;
  localparam int DMAP_BIT = 2;
  localparam int CNF_BIT = 3;
  localparam logic [2:0] MODE_RESET = 3'h6;
  // Flash control: bit0 erase-low, bit1 erase-high strobes
  localparam int ERASE_LO_BIT = 0;
  localparam int ERASE_HI_BIT = 1;
  // Register counts
  localparam logic [7:0] DATA_SPACE_REGS = 8'h03;
  localparam logic [7:0] IO_SPACE_REGS = 8'h12;
  // Address windows
  localparam logic [15:0] MMR_HI = 16'h005F;
  localparam logic [15:0] B2_LO = 16'h0060;
  localparam logic [15:0] B2_HI = 16'h007F;
  localparam logic [15:0] B0D_LO = 16'h0100;
  localparam logic [15:0] B0D_HI = 16'h02FF;
  localparam logic [15:0] B1D_LO = 16'h0300;
  localparam logic [15:0] B1D_HI = 16'h04FF;
  localparam logic [15:0] SAD_LO = 16'h0800;
  localparam logic [15:0] SAD_HI = 16'h17FF;
  localparam logic [15:0] FL_HI = 16'h7FFF;
  localparam logic [15:0] SAP_LO = 16'h8000;
  localparam logic [15:0] SAP_HI = 16'h8FFF;
  localparam logic [15:0] B0P_LO = 16'hFE00;
  localparam logic [15:0] BOOT_HI = 16'h00FF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Chip-select one-hot positions
  localparam int CS_B0 = 0;
  localparam int CS_B1 = 1;
  localparam int CS_B2 = 2;
  localparam int CS_SA = 3;
  localparam int CS_FLO = 4;
  localparam int CS_FHI = 5;
  localparam int CS_EXT = 6;
  localparam int CS_NONE = 7;
  localparam int CS_W = 8;
endpackage

//--- verilog/flash_array.sv
module flash_array
  import memmap_pkg::*;
#(
  parameter int AW = 15,
  parameter int DW = 16
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Read port, registered data
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  // Program port: clears selected bits
  input wire logic prog_en,
  input wire logic [AW-1:0] prog_addr,
  input wire logic [DW-1:0] prog_clr_mask,
  // Whole-module erase strobes
  input wire logic erase_lo,
  input wire logic erase_hi
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] nxt_rd;
  logic [DW-1:0] rd_ff;
  logic [2**AW-1:0] touched_ff;
  logic boot_gone_ff;

  always_comb
  begin
    if (!touched_ff[rd_addr])
      nxt_rd = (rd_addr <= AW'(BOOT_HI) && !boot_gone_ff) ? DW'(rd_addr) : ERASED_WORD[DW-1:0];
    else
      nxt_rd = mem[rd_addr];
  end

  always_ff @(posedge pclk)
  begin
    if (prog_en)
    begin
      if (touched_ff[prog_addr])
        mem[prog_addr] <= mem[prog_addr] & ~prog_clr_mask;
      else if (prog_addr <= AW'(BOOT_HI) && !boot_gone_ff)
        mem[prog_addr] <= DW'(prog_addr) & ~prog_clr_mask;
      else
        mem[prog_addr] <= ERASED_WORD[DW-1:0] & ~prog_clr_mask;
    end
  end

  // Touched map: erase reverts whole module to erased content
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      touched_ff <= '0;
      boot_gone_ff <= 1'b0;
      rd_ff <= '0;
    end
    else
    begin
      rd_ff <= nxt_rd;
      if (erase_lo)
      begin
        touched_ff[2**(AW-1)-1:0] <= '0;
        // Boot words lost after low erase
        boot_gone_ff <= 1'b1;
      end
      if (erase_hi)
        touched_ff[2**AW-1:2**(AW-1)] <= '0;
      if (prog_en)
        touched_ff[prog_addr] <= 1'b1;
    end
  end

  assign rd_data = rd_ff;
endmodule

//--- verilog/memory_map_decoder.sv
// How it works
// [R01] Clear block-0 bit: data 100-2FF to block zero
// [R02] Set block-0 bit: program FE00-FFFF to zero
// [R03] Data 300-4FF always to block one
// [R04] Data 60-7F always to block two
// [R05] Mode latch 0: program 0-7FFF flash
// [R06] Mode latch 1 or upper program: external
// [R07] Data map bit: data 800-17FF SARAM
// [R08] Program map bit: program 8000-8FFF SARAM
// [R09] Both windows share one SARAM
// [R10] Dual ranges alias same physical word
// [R11] Two 16K flash modules, one region
// [R12] Erased reads one, programmed reads zero
// [R13] Erase whole module; program clears bits
// [R14] Flash reads need no wait states
// [R15] Core software sequences program and erase
// [R16] Boot words 0-FF preloaded, rest erased
// [R17] Three data, eighteen I/O registers
// [R18] Mode bit captures pin, software rewritable
// [R19] Map bits reset to one
// [R20] Data 0-5F reserved for registers
// [R21] Either map bit clear: its own SARAM window external
// [R22] Exactly one chip select per access
module memory_map_decoder
  import memmap_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot pin
  input wire logic boot_mode_pin,
  // Core access
  input wire logic acc_valid,
  input wire logic acc_prog,
  input wire logic [15:0] acc_addr,
  input wire logic prog_en,
  input wire logic [15:0] prog_clr_mask,
  // Decoded selects, local offset and flash outputs
  output logic [memmap_pkg::CS_W-1:0] chip_sel,
  output logic [11:0] local_addr,
  output logic flash_wait,
  output logic [15:0] flash_rdata
);
  import memmap_pkg::*;

  logic processor_mode_latch_ff, nxt_mode;
  logic sram_program_map_enable_ff, nxt_pmap;
  logic sram_data_map_enable_ff, nxt_dmap;
  logic block0_space_select_ff, nxt_cnf;
  logic strap_pending_ff, nxt_strap;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [CS_W-1:0] cs_ff, nxt_cs;
  logic [11:0] loc_ff, nxt_loc;
  logic [1:0] erase_ff, nxt_erase;
  logic [CS_W-1:0] dec;
  logic [11:0] off;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Combinational decode
  always_comb
  begin
    dec = '0;
    off = acc_addr[11:0];
    if (!acc_prog)
    begin
      // [R20] reserved register space
      if (acc_addr <= MMR_HI)
        dec[CS_NONE] = 1'b1;
      // [R04] block two
      else if (in_rng(acc_addr, B2_LO, B2_HI))
        dec[CS_B2] = 1'b1;
      // [R01] block zero in data
      else if (in_rng(acc_addr, B0D_LO, B0D_HI))
      begin
        dec[block0_space_select_ff ? CS_NONE : CS_B0] = 1'b1;
        // [R10] alias offsets
        off = {4'h0, acc_addr[7:0]};
      end
      // [R03] block one
      else if (in_rng(acc_addr, B1D_LO, B1D_HI))
      begin
        dec[CS_B1] = 1'b1;
        off = {4'h0, acc_addr[7:0]};
      end
      // [R07] data SARAM window
      else if (in_rng(acc_addr, SAD_LO, SAD_HI) && sram_data_map_enable_ff)
      begin
        dec[CS_SA] = 1'b1;
        // [R09] shared physical words
        off = 12'(acc_addr - SAD_LO);
      end
      // data 80-FF and 500-7FF select none; unmapped SARAM falls to external
      else if (in_rng(acc_addr, 16'h0080, 16'h00FF) || in_rng(acc_addr, 16'h0500, 16'h07FF))
        dec[CS_NONE] = 1'b1;
      else
        dec[CS_EXT] = 1'b1;
    end
    else
    begin
      // [R05] flash in microcontroller mode
      if (acc_addr <= FL_HI)
      begin
        // [R11] two halves of one region
        if (processor_mode_latch_ff)
          dec[CS_EXT] = 1'b1;
        else
          dec[acc_addr[14] ? CS_FHI : CS_FLO] = 1'b1;
      end
      // [R02] block zero in program
      else if (acc_addr >= B0P_LO && block0_space_select_ff)
      begin
        dec[CS_B0] = 1'b1;
        off = {4'h0, acc_addr[7:0]};
      end
      // [R08] program SARAM window
      else if (in_rng(acc_addr, SAP_LO, SAP_HI) && sram_program_map_enable_ff)
      begin
        dec[CS_SA] = 1'b1;
        off = 12'(acc_addr - SAP_LO);
      end
      // [R06] upper program external
      else
        dec[CS_EXT] = 1'b1;
    end
  end

  // Register and APB next state
  always_comb
  begin
    nxt_mode = processor_mode_latch_ff;
    nxt_pmap = sram_program_map_enable_ff;
    nxt_dmap = sram_data_map_enable_ff;
    nxt_cnf = block0_space_select_ff;
    nxt_strap = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_erase = 2'b00;
    // [R22] one select per access
    nxt_cs = acc_valid ? dec : '0;
    nxt_loc = acc_valid ? off : '0;
    // [R18] capture strap after reset release
    if (strap_pending_ff)
      nxt_mode = boot_mode_pin;
    if (psel && !penable)
    begin
      nxt_pready = 1'b1;
      if (paddr == MODE_REG_OFF)
      begin
        if (pwrite)
        begin
          nxt_mode = pwdata[MODE_BIT];
          nxt_pmap = pwdata[PMAP_BIT];
          nxt_dmap = pwdata[DMAP_BIT];
          nxt_cnf = pwdata[CNF_BIT];
        end
        nxt_prdata = {28'h0, block0_space_select_ff, sram_data_map_enable_ff,
                      sram_program_map_enable_ff, processor_mode_latch_ff};
      end
      else if (paddr == FLASH_CTL_OFF)
      begin
        // [R13] whole-module erase strobes
        // [R15] software-driven sequence
        if (pwrite)
          nxt_erase = pwdata[1:0];
        nxt_prdata = 32'h0;
      end
      else if (paddr == STATUS_OFF)
        nxt_prdata = {24'h0, cs_ff};
      else if (paddr == REGMAP_OFF)
        // [R17] register counts
        nxt_prdata = {16'h0, IO_SPACE_REGS, DATA_SPACE_REGS};
      else
      begin
        nxt_prdata = 32'h0;
        nxt_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      processor_mode_latch_ff <= 1'b0;
      // [R19] map bits reset high
      sram_program_map_enable_ff <= MODE_RESET[PMAP_BIT];
      sram_data_map_enable_ff <= MODE_RESET[DMAP_BIT];
      block0_space_select_ff <= 1'b0;
      strap_pending_ff <= 1'b1;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      cs_ff <= '0;
      loc_ff <= '0;
      erase_ff <= 2'b00;
    end
    else
    begin
      processor_mode_latch_ff <= nxt_mode;
      sram_program_map_enable_ff <= nxt_pmap;
      sram_data_map_enable_ff <= nxt_dmap;
      block0_space_select_ff <= nxt_cnf;
      strap_pending_ff <= nxt_strap;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      cs_ff <= nxt_cs;
      loc_ff <= nxt_loc;
      erase_ff <= nxt_erase;
    end
  end

  // [R12] [R16] flash content model
  flash_array u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .rd_addr(acc_addr[14:0]),
    .rd_data(flash_rdata),
    .prog_en(prog_en),
    .prog_addr(acc_addr[14:0]),
    .prog_clr_mask(prog_clr_mask),
    .erase_lo(erase_ff[ERASE_LO_BIT]),
    .erase_hi(erase_ff[ERASE_HI_BIT])
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign chip_sel = cs_ff;
  assign local_addr = loc_ff;
  // [R14] zero wait states
  assign flash_wait = 1'b0;

  a_one_hot_sel: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    acc_valid |=> $onehot(chip_sel)) else $error("select not one-hot");
  a_b2_fixed: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
    acc_valid && !acc_prog && acc_addr inside {[16'h0060:16'h007F]} |=> chip_sel[CS_B2])
    else $error("block two miss");
  a_b1_fixed: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
    acc_valid && !acc_prog && acc_addr inside {[16'h0300:16'h04FF]} |=> chip_sel[CS_B1])
    else $error("block one miss");
  a_b0_data: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    acc_valid && !acc_prog && !block0_space_select_ff && acc_addr inside {[16'h0100:16'h02FF]}
    |=> chip_sel[CS_B0] && local_addr == {4'h0, $past(acc_addr[7:0])}) else $error("block zero data");
  a_b0_prog: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
    acc_valid && acc_prog && block0_space_select_ff && acc_addr >= 16'hFE00 |=> chip_sel[CS_B0])
    else $error("block zero prog");
  a_flash_mode: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
    acc_valid && acc_prog && !processor_mode_latch_ff && acc_addr <= 16'h7FFF
    |=> chip_sel[CS_FLO] || chip_sel[CS_FHI]) else $error("flash miss");
  a_ext_mode: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
    acc_valid && acc_prog && processor_mode_latch_ff && acc_addr <= 16'h7FFF |=> chip_sel[CS_EXT])
    else $error("external miss");
  a_sa_data: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    acc_valid && !acc_prog && sram_data_map_enable_ff && acc_addr inside {[16'h0800:16'h17FF]}
    |=> chip_sel[CS_SA]) else $error("sram data miss");
  a_sa_prog: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    acc_valid && acc_prog && sram_program_map_enable_ff && acc_addr inside {[16'h8000:16'h8FFF]}
    |=> chip_sel[CS_SA]) else $error("sram prog miss");
  a_mmr_none: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    acc_valid && !acc_prog && acc_addr <= 16'h005F |=> !chip_sel[CS_B0] && chip_sel[CS_NONE])
    else $error("register space decoded");
  a_b0_reserved: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    acc_valid && !acc_prog && block0_space_select_ff && acc_addr inside {[16'h0100:16'h02FF]}
    |=> chip_sel[CS_NONE]) else $error("block zero data not reserved");
  a_b0_alias: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    acc_valid && acc_prog && block0_space_select_ff && acc_addr >= 16'hFE00
    |=> local_addr == {4'h0, $past(acc_addr[7:0])}) else $error("block zero alias offset");
  a_flash_half: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    acc_valid && acc_prog && !processor_mode_latch_ff && acc_addr inside {[16'h4000:16'h7FFF]}
    |=> chip_sel[CS_FHI]) else $error("flash high module miss");
  a_sa_offset: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    acc_valid && !acc_prog && sram_data_map_enable_ff && acc_addr inside {[16'h0800:16'h17FF]}
    |=> local_addr == 12'($past(acc_addr) - 16'h0800)) else $error("sram offset wrong");
  a_sa_unmap_data: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    acc_valid && !acc_prog && !sram_data_map_enable_ff && acc_addr inside {[16'h0800:16'h17FF]}
    |=> chip_sel[CS_EXT]) else $error("unmapped sram data not external");
  a_sa_unmap_prog: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    acc_valid && acc_prog && !sram_program_map_enable_ff && acc_addr inside {[16'h8000:16'h8FFF]}
    |=> chip_sel[CS_EXT]) else $error("unmapped sram prog not external");
  a_map_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    presetn && strap_pending_ff |-> sram_program_map_enable_ff && sram_data_map_enable_ff)
    else $error("map bits not set after reset");
  a_strap_capture: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    presetn && strap_pending_ff && !psel |=> processor_mode_latch_ff == $past(boot_mode_pin))
    else $error("mode bit missed boot pin");
endmodule

//--- sim/core_bus_model.sv
module core_bus_model
(
  // Clock
  input wire logic pclk,
  // Core bus towards the decoder
  output logic acc_valid,
  output logic acc_prog,
  output logic [15:0] acc_addr,
  output logic prog_en,
  output logic [15:0] prog_clr_mask
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    acc_valid = 1'b0;
    acc_prog = 1'b0;
    acc_addr = 16'h0000;
    prog_en = 1'b0;
    prog_clr_mask = 16'h0000;
  end

  task automatic op(input logic p, input logic [15:0] a, input logic pg, input logic [15:0] m);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_prog <= p;
    acc_addr <= a;
    prog_en <= pg;
    prog_clr_mask <= m;
    @(posedge pclk);
    acc_valid <= 1'b0;
    prog_en <= 1'b0;
    // Released bus shows inverted address
    acc_addr <= ~a;
    prog_clr_mask <= ~m;
  endtask
endmodule

//--- sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import memmap_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic boot_mode_pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic acc_valid;
  logic acc_prog;
  logic [15:0] acc_addr;
  logic prog_en;
  logic [15:0] prog_clr_mask;
  logic [CS_W-1:0] chip_sel;
  logic [11:0] local_addr;
  logic flash_wait;
  logic [15:0] flash_rdata;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  logic [15:0] a;
  logic [15:0] corner [24] = '{16'h005F, 16'h0060, 16'h007F, 16'h0080, 16'h00FF, 16'h0100, 16'h02FF, 16'h0300,
    16'h04FF, 16'h0500, 16'h07FF, 16'h0800, 16'h17FF, 16'h1800, 16'h0000, 16'h3FFF, 16'h4000, 16'h7FFF,
    16'h8000, 16'h8FFF, 16'h9000, 16'hFDFF, 16'hFE00, 16'hFFFF};

  always #5 pclk = ~pclk;

  memory_map_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_mode_pin(boot_mode_pin), .acc_valid(acc_valid), .acc_prog(acc_prog), .acc_addr(acc_addr),
    .prog_en(prog_en), .prog_clr_mask(prog_clr_mask), .chip_sel(chip_sel), .local_addr(local_addr),
    .flash_wait(flash_wait), .flash_rdata(flash_rdata));
  core_bus_model u_core (.pclk(pclk), .acc_valid(acc_valid), .acc_prog(acc_prog), .acc_addr(acc_addr),
    .prog_en(prog_en), .prog_clr_mask(prog_clr_mask));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_mismatch++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic pin);
    boot_mode_pin <= pin;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [7:0] exp_cs(input logic p, input logic [15:0] ad, input logic [3:0] c);
    int k;
    if (p)
      k = (ad <= FL_HI) ? (c[0] ? CS_EXT : (ad[14] ? CS_FHI : CS_FLO)) : (ad <= SAP_HI) ? (c[1] ? CS_SA : CS_EXT)
        : (ad >= B0P_LO && c[3]) ? CS_B0 : CS_EXT;
    else
      k = (ad <= MMR_HI) ? CS_NONE : (ad <= B2_HI) ? CS_B2 : (ad < B0D_LO) ? CS_NONE
        : (ad <= B0D_HI) ? (c[3] ? CS_NONE : CS_B0) : (ad <= B1D_HI) ? CS_B1 : (ad < SAD_LO) ? CS_NONE
        : (ad <= SAD_HI) ? (c[2] ? CS_SA : CS_EXT) : CS_EXT;
    return 8'h01 << k;
  endfunction

  task automatic acc(input logic p, input logic [15:0] ad, input logic [3:0] c);
    logic [7:0] e;
    e = exp_cs(p, ad, c);
    u_core.op(p, ad, 1'b0, 16'h0000);
    #1;
    chk("chip_sel", {24'h0, chip_sel}, {24'h0, e});
    if (e[CS_B0] | e[CS_B1])
      chk("local_addr", {20'h0, local_addr}, {24'h0, ad[7:0]});
    if (e[CS_SA])
      chk("local_addr", {20'h0, local_addr}, {20'h0, 12'(ad - (p ? SAP_LO : SAD_LO))});
    chk("flash_wait", {31'h0, flash_wait}, 32'h0);
  endtask

  task automatic fl(input logic [15:0] ad, input logic [15:0] e);
    u_core.op(1'b1, ad, 1'b0, 16'h0000);
    #1;
    chk("flash_rdata", {16'h0, flash_rdata}, {16'h0, e});
  endtask

  initial
  begin
    rd = $urandom(82504);
    do_reset(1'b0);
    apb(1'b0, MODE_REG_OFF, 32'h0);
    chk("mode_reset", rd, 32'h6);
    apb(1'b0, REGMAP_OFF, 32'h0);
    chk("reg_counts", rd, {16'h0, IO_SPACE_REGS, DATA_SPACE_REGS});
    apb(1'b1, 12'h010, 32'hF);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    $display("test registers done");
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, MODE_REG_OFF, c);
      apb(1'b0, MODE_REG_OFF, 32'h0);
      chk("mode_rw", rd, c);
      foreach (corner[i])
        acc(i >= 14, corner[i], c[3:0]);
      for (int j = 0; j < 12; j++)
      begin
        a = $urandom;
        acc(j[0], j[1] ? a : (a & 16'h1FFF), c[3:0]);
      end
    end
    $display("test decode done");
    apb(1'b1, MODE_REG_OFF, 32'h6);
    fl(16'h0010, 16'h0010);
    fl(16'h1234, ERASED_WORD);
    u_core.op(1'b1, 16'h1234, 1'b1, 16'h00F0);
    fl(16'h1234, 16'hFF0F);
    u_core.op(1'b1, 16'h1234, 1'b1, 16'h0F00);
    fl(16'h1234, 16'hF00F);
    u_core.op(1'b1, 16'h5000, 1'b1, 16'h0001);
    fl(16'h5000, 16'hFFFE);
    apb(1'b1, FLASH_CTL_OFF, 32'h1 << ERASE_LO_BIT);
    fl(16'h1234, ERASED_WORD);
    fl(16'h0010, ERASED_WORD);
    fl(16'h5000, 16'hFFFE);
    apb(1'b1, FLASH_CTL_OFF, 32'h1 << ERASE_HI_BIT);
    fl(16'h5000, ERASED_WORD);
    apb(1'b0, FLASH_CTL_OFF, 32'h0);
    chk("flash_ctl_read", rd, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("status_idle", rd, 32'h0);
    $display("test flash done");
    do_reset(1'b1);
    apb(1'b0, MODE_REG_OFF, 32'h0);
    chk("mode_strap", rd, 32'h7);
    acc(1'b1, 16'h0100, 4'h7);
    $display("test strap done");
    final_report();
  end
endmodule
